// ### core/fsmap_pkg.sv
// Purpose: Shared constants for the fail-safe map and link supervision bank
// Assumes: 200 MHz clock, APB register access, 32-bit data, one word per register
// Notes: Register byte address is four times the register index
package fsmap_pkg;
   localparam int CLK_NS = 5;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES_DEF = (TICK_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [11:0] IDX_MAP_CD = 12'h081;
   localparam logic [11:0] IDX_MAP_EF = 12'h082;
   localparam logic [11:0] IDX_MAP_GH = 12'h083;
   localparam logic [11:0] IDX_LINK_CFG = 12'h084;
   localparam logic [11:0] IDX_IRQ_STATUS = 12'h088;
   localparam logic [11:0] IDX_IRQ_CLEAR = 12'h089;
   localparam logic [11:0] IDX_IRQ_ENABLE = 12'h08A;
   localparam logic [11:0] IDX_FS_STATUS = 12'h08B;
   localparam logic [11:0] ADDR_MAP_CD = IDX_MAP_CD << 2;
   localparam logic [11:0] ADDR_MAP_EF = IDX_MAP_EF << 2;
   localparam logic [11:0] ADDR_MAP_GH = IDX_MAP_GH << 2;
   localparam logic [11:0] ADDR_LINK_CFG = IDX_LINK_CFG << 2;
   localparam logic [11:0] ADDR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
   localparam logic [11:0] ADDR_IRQ_CLEAR = IDX_IRQ_CLEAR << 2;
   localparam logic [11:0] ADDR_IRQ_ENABLE = IDX_IRQ_ENABLE << 2;
   localparam logic [11:0] ADDR_FS_STATUS = IDX_FS_STATUS << 2;

   localparam int MAP_LO0_POS = 0;
   localparam int MAP_LO1_POS = 1;
   localparam int MAP_HI0_POS = 4;
   localparam int MAP_HI1_POS = 5;
   localparam logic [7:0] MAP_MASK = 8'h33;
   localparam int WDT_POS = 4;
   localparam int BWT_POS = 1;
   localparam int ACK_POS = 0;
   localparam logic [3:0] WDT_OFF = 4'h0;
   localparam logic [3:0] WDT_DIRECT_MIN = 4'hC;
   localparam int IRQ_FS_ENTER = 0;
   localparam int IRQ_FS_EXIT = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int EEP_CD_POS = 0;
   localparam int EEP_EF_POS = 8;
   localparam int EEP_GH_POS = 16;
   localparam int EEP_LINK_POS = 24;

   typedef enum logic [0:0] {
      ST_LOAD = 1'b0,
      ST_RUN = 1'b1
   } bank_state_e;

   // Watchdog timeout in microseconds, zero where no timer runs
   function automatic logic [18:0] wd_timeout_us(input logic [3:0] code);
      logic [18:0] us;
      us = 19'h00000;
      unique case (code)
         4'h1: us = 19'd200;
         4'h2: us = 19'd500;
         4'h3: us = 19'd1000;
         4'h4: us = 19'd2000;
         4'h5: us = 19'd5000;
         4'h6: us = 19'd10000;
         4'h7: us = 19'd20000;
         4'h8: us = 19'd50000;
         4'h9: us = 19'd100000;
         4'hA: us = 19'd200000;
         4'hB: us = 19'd500000;
         default: us = 19'h00000;
      endcase
      return us;
   endfunction

   // Break waiting time in microseconds
   function automatic logic [12:0] break_wait_us(input logic [2:0] code);
      logic [12:0] us;
      us = 13'h0000;
      unique case (code)
         3'h0: us = 13'd1000;
         3'h1: us = 13'd125;
         3'h2: us = 13'd250;
         3'h3: us = 13'd500;
         3'h4: us = 13'd1250;
         3'h5: us = 13'd2500;
         3'h6: us = 13'd5000;
         3'h7: us = 13'd5000;
      endcase
      return us;
   endfunction
endpackage

// ### core/link_watchdog.sv
// Purpose: Communication watchdog timer with a microsecond tick divider
// Assumes: Code and restart come from logic on the same clock
// Notes: Expiry is a one-cycle pulse, then the timer waits for a restart
`timescale 1ns/1ps
module link_watchdog #(
   parameter int TICK_CYCLES = fsmap_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] code_i,
   input wire logic restart_i,
   output logic expired_o
);
   typedef struct packed {
      logic [15:0] div;
      logic [18:0] cnt;
      logic done;
      logic expired;
   } wd_s;

   wd_s q;
   wd_s d;
   logic [18:0] limit;
   logic tick;

   always_comb begin
      d = q;
      d.expired = 1'b0;
      limit = fsmap_pkg::wd_timeout_us(code_i);
      tick = (q.div == 16'(TICK_CYCLES - 1));
      if (restart_i) begin
         d.div = 16'h0000;
         d.cnt = 19'h00000;
         d.done = 1'b0;
      end else if (limit != 19'h00000 && !q.done) begin
         d.div = tick ? 16'h0000 : q.div + 16'h0001;
         if (tick) begin
            d.cnt = q.cnt + 19'h00001;
            if (q.cnt + 19'h00001 >= limit) begin
               d.done = 1'b1;
               d.expired = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expired_o = q.expired;
endmodule

// ### core/failsafe_bank.sv
// Purpose: Fail-safe channel map and link supervision register bank on APB
// Assumes: EEPROM image and link activity come from logic on this clock
// Notes: Fail-safe inputs are pins and pass a two-stage synchroniser
// Functional notes
// - Map register cd holds c0, c1 at 0,1
// - Map register cd holds d1, d0 at 5,4
// - Map register ef holds e1, e0 at 1,0
// - Map register ef holds f1, f0 at 5,4
// - Map register gh holds g1, g0 at 1,0
// - Map register gh holds h1, h0 at 5,4
// - Fail-safe channel follows input a or b
// - Watchdog code in bits 7-4, zero disables
// - Codes 1 to B select 200us to 500ms
// - Codes C to F enter fail-safe at once
// - Break wait code in bits 3-1
// - Bit 0 enables bus acknowledgements
// - Fields load from EEPROM image after reset
`timescale 1ns/1ps
module failsafe_bank #(
   parameter int TICK_CYCLES = fsmap_pkg::TICK_CYCLES_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [11:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [31:0] eeprom_image_i,
   input wire logic link_txn_i,
   input wire logic failsafe_input_a,
   input wire logic failsafe_input_b,
   input wire logic [11:0] chan_drive_i,
   output logic [11:0] chan_out_o,
   output logic failsafe_state_o,
   output logic acknowledge_enable,
   output logic [2:0] break_wait_time,
   output logic [12:0] break_wait_us_o,
   output logic irq_o
);
   typedef struct packed {
      fsmap_pkg::bank_state_e st;
      logic [7:0] map_cd;
      logic [7:0] map_ef;
      logic [7:0] map_gh;
      logic [7:0] link_cfg;
      logic [1:0] irq_stat;
      logic [1:0] irq_en;
      logic fs;
      logic [1:0] fs_in_s1;
      logic [1:0] fs_in_s2;
      logic [11:0] chan;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
      logic ack_en;
      logic [2:0] bwt;
      logic [12:0] bwt_us;
   } bank_s;

   bank_s q;
   bank_s d;
   logic wd_expired;
   logic wd_restart;
   logic acc;
   logic wr_en;
   logic [3:0] wdt;
   logic direct;
   logic [1:0] ev;
   logic [1:0] clr;
   logic [11:0] sel;

   function automatic logic mapped(input logic [11:0] a);
      return a == fsmap_pkg::ADDR_MAP_CD || a == fsmap_pkg::ADDR_MAP_EF ||
         a == fsmap_pkg::ADDR_MAP_GH || a == fsmap_pkg::ADDR_LINK_CFG ||
         a == fsmap_pkg::ADDR_IRQ_STATUS || a == fsmap_pkg::ADDR_IRQ_CLEAR ||
         a == fsmap_pkg::ADDR_IRQ_ENABLE || a == fsmap_pkg::ADDR_FS_STATUS;
   endfunction

   // Channel select bits in order c0 c1 d0 d1 ... h0 h1
   function automatic logic [3:0] pair_bits(input logic [7:0] m);
      return {m[fsmap_pkg::MAP_HI1_POS], m[fsmap_pkg::MAP_HI0_POS],
         m[fsmap_pkg::MAP_LO1_POS], m[fsmap_pkg::MAP_LO0_POS]};
   endfunction

   link_watchdog #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_wd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .code_i(wdt),
      .restart_i(wd_restart),
      .expired_o(wd_expired)
   );

   always_comb begin
      d = q;
      acc = psel_i && penable_i && q.st == fsmap_pkg::ST_RUN;
      wr_en = acc && q.pready && pwrite_i && mapped(paddr_i);
      wdt = q.link_cfg[fsmap_pkg::WDT_POS +: 4];
      direct = wdt >= fsmap_pkg::WDT_DIRECT_MIN;
      wd_restart = link_txn_i || (wr_en && paddr_i == fsmap_pkg::ADDR_LINK_CFG);
      sel = {pair_bits(q.map_gh), pair_bits(q.map_ef), pair_bits(q.map_cd)};
      clr = 2'b00;
      d.fs_in_s1 = {failsafe_input_b, failsafe_input_a};
      d.fs_in_s2 = q.fs_in_s1;
      unique case (q.st)
         fsmap_pkg::ST_LOAD: begin
            d.map_cd = eeprom_image_i[fsmap_pkg::EEP_CD_POS +: 8] & fsmap_pkg::MAP_MASK;
            d.map_ef = eeprom_image_i[fsmap_pkg::EEP_EF_POS +: 8] & fsmap_pkg::MAP_MASK;
            d.map_gh = eeprom_image_i[fsmap_pkg::EEP_GH_POS +: 8] & fsmap_pkg::MAP_MASK;
            d.link_cfg = eeprom_image_i[fsmap_pkg::EEP_LINK_POS +: 8];
            d.st = fsmap_pkg::ST_RUN;
         end
         fsmap_pkg::ST_RUN: begin
            if (wr_en) begin
               unique case (paddr_i)
                  fsmap_pkg::ADDR_MAP_CD: d.map_cd = pwdata_i[7:0] & fsmap_pkg::MAP_MASK;
                  fsmap_pkg::ADDR_MAP_EF: d.map_ef = pwdata_i[7:0] & fsmap_pkg::MAP_MASK;
                  fsmap_pkg::ADDR_MAP_GH: d.map_gh = pwdata_i[7:0] & fsmap_pkg::MAP_MASK;
                  fsmap_pkg::ADDR_LINK_CFG: d.link_cfg = pwdata_i[7:0];
                  fsmap_pkg::ADDR_IRQ_CLEAR: clr = pwdata_i[1:0];
                  fsmap_pkg::ADDR_IRQ_ENABLE: d.irq_en = pwdata_i[1:0];
                  default: clr = 2'b00;
               endcase
            end
         end
      endcase
      // Answer in the second access cycle
      if (acc && !q.pready) begin
         d.pready = 1'b1;
         d.pslverr = !mapped(paddr_i);
         d.prdata = 32'h00000000;
         unique case (paddr_i)
            fsmap_pkg::ADDR_MAP_CD: d.prdata = {24'h000000, q.map_cd};
            fsmap_pkg::ADDR_MAP_EF: d.prdata = {24'h000000, q.map_ef};
            fsmap_pkg::ADDR_MAP_GH: d.prdata = {24'h000000, q.map_gh};
            fsmap_pkg::ADDR_LINK_CFG: d.prdata = {24'h000000, q.link_cfg};
            fsmap_pkg::ADDR_IRQ_STATUS: d.prdata = {30'h00000000, q.irq_stat};
            fsmap_pkg::ADDR_IRQ_ENABLE: d.prdata = {30'h00000000, q.irq_en};
            fsmap_pkg::ADDR_FS_STATUS: d.prdata = {31'h00000000, q.fs};
            default: d.prdata = 32'h00000000;
         endcase
      end else begin
         d.pready = 1'b0;
         d.pslverr = 1'b0;
      end
      // Entry beats exit; code zero never enters on its own
      if (q.st == fsmap_pkg::ST_RUN) begin
         if (direct || (wdt != fsmap_pkg::WDT_OFF && wd_expired)) begin
            d.fs = 1'b1;
         end else if (link_txn_i) begin
            d.fs = 1'b0;
         end
      end
      ev = 2'b00;
      ev[fsmap_pkg::IRQ_FS_ENTER] = d.fs && !q.fs;
      ev[fsmap_pkg::IRQ_FS_EXIT] = !d.fs && q.fs;
      d.irq_stat = (q.irq_stat & ~clr) | ev;
      d.irq = |(d.irq_stat & d.irq_en);
      for (int i = 0; i < 12; i++) begin
         d.chan[i] = q.fs ? (sel[i] ? q.fs_in_s2[1] : q.fs_in_s2[0]) : chan_drive_i[i];
      end
      d.ack_en = d.link_cfg[fsmap_pkg::ACK_POS];
      d.bwt = d.link_cfg[fsmap_pkg::BWT_POS +: 3];
      d.bwt_us = fsmap_pkg::break_wait_us(d.bwt);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;
   assign chan_out_o = q.chan;
   assign failsafe_state_o = q.fs;
   assign acknowledge_enable = q.ack_en;
   assign break_wait_time = q.bwt;
   assign break_wait_us_o = q.bwt_us;
   assign irq_o = q.irq;

   map_rsv_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((q.map_cd | q.map_ef | q.map_gh) & ~fsmap_pkg::MAP_MASK) == 8'h00)
      else $error("reserved map bits set");

   eeprom_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      q.st == fsmap_pkg::ST_LOAD |=> q.map_cd == ($past(eeprom_image_i[7:0]) & 8'h33)
      && q.link_cfg == $past(eeprom_image_i[31:24]))
      else $error("bank not loaded from image");

   chan_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      q.fs |=> chan_out_o[3] == ($past(q.map_cd[5]) ? $past(q.fs_in_s2[1])
      : $past(q.fs_in_s2[0])))
      else $error("channel d1 not following mapped input");

   wd_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      q.st == fsmap_pkg::ST_RUN && !q.fs && wdt == 4'h0 && !wr_en |=> !q.fs)
      else $error("fail-safe entered with watchdog off");

   direct_fs_a: assert property (@(posedge clk_i) disable iff (rst_i)
      q.st == fsmap_pkg::ST_RUN && q.link_cfg[7:6] == 2'b11 |=> failsafe_state_o)
      else $error("direct code did not enter fail-safe");

   wd_expire_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wd_expired && wdt != 4'h0 |=> failsafe_state_o)
      else $error("expiry did not enter fail-safe");

   ack_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en && paddr_i == fsmap_pkg::ADDR_LINK_CFG ##1 1'b1 |=> acknowledge_enable
      == $past(q.link_cfg[0]) && break_wait_time == $past(q.link_cfg[3:1]))
      else $error("link fields not applied");

   apb_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      acc && !q.pready |=> pready_o ##1 !pready_o)
      else $error("apb answer not one cycle");

   irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(q.irq_stat & q.irq_en))
      else $error("interrupt level mismatch");

   fs_enter_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(failsafe_state_o));
   fs_exit_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(failsafe_state_o));
   irq_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
   link_wr_c: cover property (@(posedge clk_i) disable iff (rst_i)
      wr_en && paddr_i == fsmap_pkg::ADDR_LINK_CFG);
endmodule

// ### dv/host_link_model.sv
// Purpose: Host side of the serial link, sending valid transactions
// Assumes: Same clock as the bank
// Notes: Raising en_i sends one pulse at once, then one every gap_i cycles
`timescale 1ns/1ps
module host_link_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [15:0] gap_i,
   output logic link_txn_o
);
   logic [15:0] cnt_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 16'h0000;
         link_txn_o <= 1'b0;
      end else begin
         link_txn_o <= en_i && cnt_q == 16'h0000;
         if (!en_i) begin
            cnt_q <= 16'h0000;
         end else if (cnt_q == 16'h0000) begin
            cnt_q <= gap_i - 16'h0001;
         end else begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end
endmodule

// ### dv/failsafe_bank_tb.sv
// Purpose: Self-checking bench for the fail-safe map and link bank
// Assumes: Watchdog tick shortened to 2 cycles per microsecond
// Notes: Register model held in mdl, one byte per register
`timescale 1ns/1ps
module failsafe_bank_tb;
   localparam logic [11:0] A_MAP = fsmap_pkg::ADDR_MAP_CD;
   localparam logic [11:0] A_LINK = fsmap_pkg::ADDR_LINK_CFG;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [11:0] paddr_i = 12'h000;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, eep = 32'h0, rd, d;
   logic pready_o, pslverr_o, err, link_txn, fs_a = 1'b0, fs_b = 1'b0, host_en = 1'b0;
   logic [11:0] chan_drive_i = 12'h000, chan_out_o;
   logic fs_o, ack_o, irq_o;
   logic [2:0] bwt_o;
   logic [12:0] bwus_o;
   int miscompares = 0, checks_done = 0, mdl[4], cyc;
   int bw_us[8] = '{1000, 125, 250, 500, 1250, 2500, 5000, 5000};
   always #2.5 clk_i = ~clk_i;
   failsafe_bank #(.TICK_CYCLES(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .eeprom_image_i(eep),
      .link_txn_i(link_txn), .failsafe_input_a(fs_a), .failsafe_input_b(fs_b),
      .chan_drive_i(chan_drive_i), .chan_out_o(chan_out_o), .failsafe_state_o(fs_o),
      .acknowledge_enable(ack_o), .break_wait_time(bwt_o), .break_wait_us_o(bwus_o),
      .irq_o(irq_o));
   host_link_model host (.clk_i(clk_i), .rst_i(rst_i), .en_i(host_en), .gap_i(16'd100),
      .link_txn_o(link_txn));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         chk("pready", 0, 1);
         wrap_up();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask
   task automatic link_pulse();
      @(posedge clk_i);
      host_en <= 1'b1;
      @(posedge clk_i);
      host_en <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic wait_fs(input logic v, input int lim);
      cyc = 0;
      while (fs_o !== v && cyc < lim) begin
         @(posedge clk_i);
         cyc++;
      end
      chk("fs_state", fs_o, v);
      if (cyc >= lim) begin
         wrap_up();
      end
   endtask
   function automatic logic [11:0] fs_exp(input logic a, input logic b);
      for (int k = 0; k < 12; k++) fs_exp[k] = mdl[k / 4][k % 4 + (k % 4 > 1 ? 2 : 0)] ? b : a;
   endfunction
   initial begin
      void'($urandom(32'h4d1ac3b4));
      eep = $urandom();
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) mdl[i] = eep[8 * i +: 8] & (i < 3 ? 8'h33 : 8'hFF);
      repeat (3) @(posedge clk_i);
      for (int i = 0; i < 4; i++) rdc("reset_val", A_MAP + 12'(4 * i), mdl[i]);
      chk("ack_reset", ack_o, mdl[3][0]);
      chk("bwus_reset", bwus_o, bw_us[mdl[3][3:1]]);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped_err", err, 1);
      chk("unmapped_rd", rd, 0);
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 2; j++) begin
            d = j ? $urandom() : 32'hFFFF_FFFF;
            apb(1'b1, A_MAP + 12'(4 * i), d);
            mdl[i] = d & 32'h33;
            rdc("map", A_MAP + 12'(4 * i), mdl[i]);
         end
      end
      for (int c = 0; c < 8; c++) begin
         mdl[3] = (c << 1) | (c & 1);
         apb(1'b1, A_LINK, mdl[3]);
         repeat (3) @(posedge clk_i);
         chk("bwt", bwt_o, c);
         chk("bwus", bwus_o, bw_us[c]);
         chk("ack", ack_o, c & 1);
      end
      rdc("link", A_LINK, mdl[3]);
      link_pulse();
      repeat (1000) @(posedge clk_i);
      chk("wd_off", fs_o, 0);
      apb(1'b1, A_LINK, 32'hC0);
      wait_fs(1'b1, 20);
      link_pulse();
      chk("direct_stays", fs_o, 1);
      for (int p = 0; p < 4; p++) begin
         fs_a <= p[0];
         fs_b <= p[1];
         chan_drive_i <= 12'($urandom());
         repeat (6) @(posedge clk_i);
         chk("chan", chan_out_o, fs_exp(p[0], p[1]));
      end
      apb(1'b1, A_LINK, 32'h10);
      link_pulse();
      wait_fs(1'b0, 20);
      chk("chan_normal", chan_out_o, chan_drive_i);
      apb(1'b1, fsmap_pkg::ADDR_IRQ_CLEAR, 32'h3);
      host_en <= 1'b1;
      repeat (1500) @(posedge clk_i);
      chk("traffic_keeps", fs_o, 0);
      host_en <= 1'b0;
      apb(1'b1, A_LINK, 32'h10);
      wait_fs(1'b1, 1000);
      chk("timeout", cyc >= 395 && cyc <= 410, 1);
      rdc("irq_stat", fsmap_pkg::ADDR_IRQ_STATUS, 32'h1);
      rdc("fs_status", fsmap_pkg::ADDR_FS_STATUS, 32'h1);
      chk("irq_masked", irq_o, 0);
      apb(1'b1, fsmap_pkg::ADDR_IRQ_ENABLE, 32'h1);
      repeat (3) @(posedge clk_i);
      chk("irq_on", irq_o, 1);
      apb(1'b1, fsmap_pkg::ADDR_IRQ_CLEAR, 32'h1);
      repeat (3) @(posedge clk_i);
      chk("irq_off", irq_o, 0);
      rdc("irq_clr_rd", fsmap_pkg::ADDR_IRQ_CLEAR, 32'h0);
      link_pulse();
      chk("exit_masked", irq_o, 0);
      rdc("irq_exit", fsmap_pkg::ADDR_IRQ_STATUS, 32'h2);
      wrap_up();
   end
endmodule
